// ==== pkg/flash_if_pkg.sv ====
/*
 * Shared constants and carrier types for the serial flash front end.
 * Assumes a single system clock that oversamples the serial link.
 */
package flash_if_pkg;
   // ***********************************************
   // Memory geometry
   // ***********************************************
   localparam int SECTORS      = 4;
   localparam int PAGES_PER_SEC = 128;
   localparam int PAGE_BYTES   = 256;
   localparam int ADDR_W       = 17;
   localparam int PAGE_W       = 8;
   localparam int SECTOR_LSB   = 15;
   localparam int BYTE_BITS    = 8;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [1:0] GUARD_RST = 2'h0;

   // ***********************************************
   // Carrier types
   // ***********************************************
   // Decoded byte handed to the command layer
   typedef struct packed {
      logic       valid;
      logic       first;
      logic [7:0] data;
   } rx_byte_s;

   // Erase/program request to the array sequencer
   typedef struct packed {
      logic              prog;
      logic              erase_sec;
      logic              erase_all;
      logic [ADDR_W-1:0] addr;
   } op_req_s;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_XFER  = 3'b010,
      ST_PAUSE = 3'b100
   } link_state_e;
endpackage : flash_if_pkg

// ==== verilog/flash_spi_front.sv ====
/*
 * Serial link front end of a small serial flash: edge detection,
 * bit shifting, select/pause handling, standby and array operation requests.
 * Assumes all link pins are asynchronous to MCLK and the link clock
 * runs well below a quarter of MCLK.
 */
`timescale 1ns/1ps
`default_nettype none
module flash_spi_front #(
   parameter int SYNC_STAGES = 2
) (
   input  wire logic                              MCLK,
   input  wire logic                              NRST,
   input  wire logic                              SCLK,
   input  wire logic                              SEL_N,
   input  wire logic                              SDI,
   input  wire logic                              PAUSE_N,
   input  wire logic                              PROTECT_N,
   input  wire logic                              BUSY,
   input  wire logic [7:0]                        TX_DATA,
   input  wire logic [1:0]                        GUARD_WR_DATA,
   input  wire logic                              GUARD_WR,
   input  wire logic                              PROTECT_ENA,
   output logic                                   SDO,
   output logic                                   SDO_OE,
   output logic                                   STANDBY,
   output logic                                   ACTIVE,
   output logic                                   TX_LOAD,
   output flash_if_pkg::rx_byte_s                 RX_BYTE,
   output flash_if_pkg::op_req_s                  OP_REQ,
   output logic [1:0]                             GUARD
);
   // ***********************************************
   // Elaboration checks
   // ***********************************************
   if (SYNC_STAGES != 2) begin : g_bad
      $error("SYNC_STAGES must be 2");
   end

   // ***********************************************
   // Pin synchronisers
   // ***********************************************
   // Two stages per pin; only stage two is read by logic
   // No reset here: a pin held low through reset must never look like
   // a fresh edge once reset lifts, so the stages track the pins always
   logic [4:0] meta_ff;
   logic [4:0] sync_ff;
   logic [4:0] pins;
   assign pins = {SCLK, SEL_N, SDI, PAUSE_N, PROTECT_N};
   genvar gi;
   for (gi = 0; gi < 5; gi++) begin : g_sync
      always_ff @(posedge MCLK) begin
         meta_ff[gi] <= pins[gi];
         sync_ff[gi] <= meta_ff[gi];
      end
   end
   wire sclk_s    = sync_ff[4];
   wire sel_n_s   = sync_ff[3];
   wire sdi_s     = sync_ff[2];
   wire pause_n_s = sync_ff[1];
   wire prot_n_s  = sync_ff[0];

   // ***********************************************
   // Edge detection
   // ***********************************************
   logic sclk_d_ff;
   logic sel_d_ff;
   // Delayed copies follow the pins through reset, so no false edge after it
   always_ff @(posedge MCLK) begin
      sclk_d_ff <= sclk_s;
      sel_d_ff  <= sel_n_s;
   end
   // idle level agnostic
   // Edges only count inside a frame, so idle high or low is fine
   wire sclk_rise = sclk_s & ~sclk_d_ff;
   wire sclk_fall = ~sclk_s & sclk_d_ff;
   wire sel_fall  = ~sel_n_s & sel_d_ff;
   wire sel_rise  = sel_n_s & ~sel_d_ff;

   // ***********************************************
   // Link state
   // ***********************************************
   flash_if_pkg::link_state_e state_ff;
   flash_if_pkg::link_state_e nxt_state;
   logic armed_ff;
   logic nxt_armed;
   // arm on select fall
   // Power-up select level is never trusted; only a falling edge arms
   assign nxt_armed = armed_ff | sel_fall;
   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         armed_ff <= 1'b0;
      end else begin
         armed_ff <= nxt_armed;
      end
   end

   wire pause_req  = ~pause_n_s & ~sel_n_s;
   wire pause_go   = pause_req & ~sclk_s;
   wire pause_end  = pause_n_s & ~sclk_s;
   wire frame_ok   = ~sel_n_s & armed_ff;

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         flash_if_pkg::ST_IDLE: begin
            if (sel_fall) begin
               nxt_state = flash_if_pkg::ST_XFER;
            end
         end
         flash_if_pkg::ST_XFER: begin
            if (sel_n_s) begin
               nxt_state = flash_if_pkg::ST_IDLE;
            end else if (pause_go) begin
               nxt_state = flash_if_pkg::ST_PAUSE;
            end
         end
         flash_if_pkg::ST_PAUSE: begin
            if (sel_n_s) begin
               nxt_state = flash_if_pkg::ST_IDLE;
            end else if (pause_end) begin
               nxt_state = flash_if_pkg::ST_XFER;
            end
         end
         default: nxt_state = flash_if_pkg::ST_IDLE;
      endcase
   end
   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         state_ff <= flash_if_pkg::ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end
   wire in_xfer = (state_ff == flash_if_pkg::ST_XFER) & frame_ok;

   // ***********************************************
   // Bit shifting
   // ***********************************************
   logic [2:0] bit_ff;
   logic [6:0] sh_ff;
   logic       first_ff;
   logic [7:0] tx_ff;
   wire take_bit = in_xfer & sclk_rise;
   wire byte_end = take_bit & (bit_ff == flash_if_pkg::BIT_LAST);
   wire drive_bit = in_xfer & sclk_fall;
   wire restart = (state_ff == flash_if_pkg::ST_IDLE);
   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         bit_ff   <= 3'h0;
         sh_ff    <= 7'h00;
         first_ff <= 1'b1;
      end else if (restart) begin
         bit_ff   <= 3'h0;
         first_ff <= 1'b1;
      end else if (take_bit) begin
         sh_ff  <= {sh_ff[5:0], sdi_s};
         bit_ff <= bit_ff + 3'h1;
         if (byte_end) begin
            first_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         RX_BYTE <= '0;
      end else begin
         RX_BYTE.valid <= byte_end;
         RX_BYTE.first <= byte_end & first_ff;
         if (byte_end) begin
            RX_BYTE.data <= {sh_ff, sdi_s};
         end
      end
   end

   // launch on falling edge
   // Byte reload happens on the fall that ends the previous byte
   wire reload = drive_bit & (bit_ff == 3'h0);
   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         tx_ff   <= 8'hFF;
         SDO     <= 1'b0;
         TX_LOAD <= 1'b0;
      end else begin
         TX_LOAD <= reload;
         if (reload) begin
            tx_ff <= {TX_DATA[6:0], 1'b0};
            SDO   <= TX_DATA[7];
         end else if (drive_bit) begin
            tx_ff <= {tx_ff[6:0], 1'b0};
            SDO   <= tx_ff[7];
         end
      end
   end

   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         SDO_OE <= 1'b0;
      end else begin
         SDO_OE <= (nxt_state == flash_if_pkg::ST_XFER) & ~sel_n_s & armed_ff;
      end
   end

   // ***********************************************
   // Power mode
   // ***********************************************
   // standby unless selected or busy
   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         ACTIVE  <= 1'b0;
         STANDBY <= 1'b1;
      end else begin
         ACTIVE  <= ~sel_n_s | BUSY;
         STANDBY <= sel_n_s & ~BUSY;
      end
   end

   // ***********************************************
   // Block guard bits
   // ***********************************************
   // protect pin freezes guard
   wire guard_lock = PROTECT_ENA & ~prot_n_s;
   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         GUARD <= flash_if_pkg::GUARD_RST;
      end else if (GUARD_WR & ~guard_lock) begin
         GUARD <= GUARD_WR_DATA;
      end
   end

   // ***********************************************
   // Array operation requests
   // ***********************************************
   // Byte index: 1 after command, 4 once three address bytes are in
   logic [2:0]                     idx_ff;
   logic [7:0]                     cmd_ff;
   logic [flash_if_pkg::ADDR_W-1:0] adr_ff;
   logic [8:0]                     cnt_ff;
   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         idx_ff <= 3'h0;
         cmd_ff <= 8'h00;
         adr_ff <= '0;
         cnt_ff <= 9'h000;
      end else if (restart) begin
         idx_ff <= 3'h0;
         cnt_ff <= 9'h000;
      end else if (RX_BYTE.valid) begin
         if (RX_BYTE.first) begin
            idx_ff <= 3'h1;
         end else if (idx_ff != 3'h4) begin
            idx_ff <= idx_ff + 3'h1;
         end
         if (RX_BYTE.first) begin
            cmd_ff <= RX_BYTE.data;
         end else if (idx_ff != 3'h4) begin
            adr_ff <= {adr_ff[flash_if_pkg::ADDR_W-9:0], RX_BYTE.data};
         end else if (cnt_ff != 9'(flash_if_pkg::PAGE_BYTES)) begin
            cnt_ff <= cnt_ff + 9'h001;
         end
      end
   end

   // Requests issue at deselect, when the byte count is known
   wire [7:0] cmd_prog = 8'h02;
   wire [7:0] cmd_sec  = 8'hD8;
   wire [7:0] cmd_all  = 8'hC7;
   wire whole = (bit_ff == 3'h0);
   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         OP_REQ <= '0;
      end else begin
         OP_REQ.prog <= sel_rise & whole & (cmd_ff == cmd_prog) & (cnt_ff != 9'h000);
         OP_REQ.erase_sec <= sel_rise & whole & (cmd_ff == cmd_sec) & (idx_ff == 3'h4);
         OP_REQ.erase_all <= sel_rise & whole & (cmd_ff == cmd_all) & (idx_ff == 3'h1);
         if (sel_rise) begin
            OP_REQ.addr <= adr_ff;
         end
      end
   end
endmodule : flash_spi_front
`default_nettype wire

// ==== tb/flash_spi_front_sva.sv ====
/* Checker bound to the serial flash front end.
   Sees only top ports; link pins reach MCLK through a 2 FF sync. */
`timescale 1ns/1ps
`default_nettype none
module flash_spi_front_sva (
   input wire logic                   MCLK,
   input wire logic                   NRST,
   input wire logic                   SCLK,
   input wire logic                   SEL_N,
   input wire logic                   PAUSE_N,
   input wire logic                   PROTECT_N,
   input wire logic                   BUSY,
   input wire logic                   PROTECT_ENA,
   input wire logic                   SDO,
   input wire logic                   SDO_OE,
   input wire logic                   STANDBY,
   input wire logic                   ACTIVE,
   input wire flash_if_pkg::rx_byte_s RX_BYTE,
   input wire flash_if_pkg::op_req_s  OP_REQ,
   input wire logic [1:0]             GUARD
);
   // ****************
   // Link checks
   // ****************
   default clocking @(posedge MCLK); endclocking
   default disable iff (!NRST);
   property p_oe_desel; SEL_N [*5] |-> !SDO_OE; endproperty
   a_oe_desel: assert property (p_oe_desel) else $error("out driven deselected");
   property p_oe_pause; (!PAUSE_N && !SEL_N && !SCLK) [*8] |-> !SDO_OE; endproperty
   a_oe_pause: assert property (p_oe_pause) else $error("out driven in pause");
   property p_standby; (SEL_N && !BUSY) [*6] |-> STANDBY && !ACTIVE; endproperty
   a_standby: assert property (p_standby) else $error("no standby");
   property p_busy_act; BUSY [*5] |-> ACTIVE && !STANDBY; endproperty
   a_busy_act: assert property (p_busy_act) else $error("standby while busy");
   property p_sel_act; $fell(SEL_N) ##1 !SEL_N [*4] |-> ACTIVE && !STANDBY; endproperty
   a_sel_act: assert property (p_sel_act) else $error("not active when selected");
   // Only one look per high phase: the fall launches, the high phase holds
   property p_sdo_hold; SDO_OE && $past(SDO_OE, 4) && SCLK && $past(SCLK, 3) |-> $stable(SDO);
   endproperty
   a_sdo_hold: assert property (p_sdo_hold) else $error("out moved in high phase");
   property p_guard; (PROTECT_ENA && !PROTECT_N) [*4] |=> $stable(GUARD); endproperty
   a_guard: assert property (p_guard) else $error("guard changed while frozen");
   property p_rx_pulse; RX_BYTE.valid |=> !RX_BYTE.valid [*8]; endproperty
   a_rx_pulse: assert property (p_rx_pulse) else $error("bytes too close");
   property p_op_req; OP_REQ.prog || OP_REQ.erase_sec || OP_REQ.erase_all
      |-> SEL_N && $onehot({OP_REQ.prog, OP_REQ.erase_sec, OP_REQ.erase_all}); endproperty
   a_op_req: assert property (p_op_req) else $error("bad operation request");
endmodule : flash_spi_front_sva
bind flash_spi_front flash_spi_front_sva chk (
   .MCLK(MCLK), .NRST(NRST), .SCLK(SCLK), .SEL_N(SEL_N), .PAUSE_N(PAUSE_N),
   .PROTECT_N(PROTECT_N), .BUSY(BUSY), .PROTECT_ENA(PROTECT_ENA), .SDO(SDO),
   .SDO_OE(SDO_OE), .STANDBY(STANDBY), .ACTIVE(ACTIVE), .RX_BYTE(RX_BYTE),
   .OP_REQ(OP_REQ), .GUARD(GUARD));
`default_nettype wire

// ==== tb/spi_master_model.sv ====
/* Link master model for the flash front end.
   Assumes MCLK paces it: a half link period is 4 MCLK cycles. */
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
   input  wire logic MCLK,
   input  wire logic SDO,
   output var logic  SCLK,
   output var logic  SEL_N,
   output var logic  SDI,
   output var logic  PAUSE_N
);
   // ****************
   // Master tasks
   // ****************
   logic idle_lvl;
   initial begin
      idle_lvl = 1'b0;
      SCLK     = 1'b0;
      SEL_N    = 1'b0;
      SDI      = 1'b0;
      PAUSE_N  = 1'b1;
   end
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge MCLK);
      #1;
   endtask : wait_cyc
   task automatic open(input logic m3);
      idle_lvl = m3;
      SCLK     = m3;
      wait_cyc(4);
      SEL_N = 1'b0;
      wait_cyc(6);
   endtask : open
   task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         SCLK = 1'b0;
         SDI  = tx[i];
         wait_cyc(4);
         SCLK = 1'b1;
         wait_cyc(2);
         rx[i] = SDO; // Mid high phase, well clear of the launch
         wait_cyc(2);
      end
   endtask : shift
   // One device selected at a time
   task automatic close();
      SCLK = idle_lvl;
      wait_cyc(4);
      SEL_N = 1'b1;
      SDI   = ~SDI; // Released line shows no stale bit
      wait_cyc(8);
   endtask : close
   task automatic hold_on(input int n);
      SCLK    = 1'b0;
      PAUSE_N = 1'b0;
      wait_cyc(12);
      for (int i = 0; i < n; i++) begin
         SCLK = ~SCLK;
         SDI  = ~SDI;
         wait_cyc(4);
      end
      SCLK = 1'b0;
      wait_cyc(4);
   endtask : hold_on
   task automatic hold_off();
      PAUSE_N = 1'b1;
      wait_cyc(6);
   endtask : hold_off
endmodule : spi_master_model
`default_nettype wire

// ==== tb/tb.sv ====
/* Self-checking bench for the flash front end.
   Assumes the link master model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb;
   // ****************
   // Bench
   // ****************
   logic MCLK, NRST, PROTECT_N, BUSY, GUARD_WR, PROTECT_ENA, SCLK, SEL_N, SDI, PAUSE_N;
   logic SDO, SDO_OE, STANDBY, ACTIVE, TX_LOAD, sdo_line;
   logic [7:0] TX_DATA;
   logic [1:0] GUARD_WR_DATA, GUARD;
   flash_if_pkg::rx_byte_s RX_BYTE;
   flash_if_pkg::op_req_s  OP_REQ, last_op;
   logic [8:0] rx_q [$];
   int n_errors = 0;
   int comparisons = 0;
   int n_loads = 0;
   flash_spi_front dut (
      .MCLK(MCLK), .NRST(NRST), .SCLK(SCLK), .SEL_N(SEL_N), .SDI(SDI),
      .PAUSE_N(PAUSE_N), .PROTECT_N(PROTECT_N), .BUSY(BUSY), .TX_DATA(TX_DATA),
      .GUARD_WR_DATA(GUARD_WR_DATA), .GUARD_WR(GUARD_WR), .PROTECT_ENA(PROTECT_ENA),
      .SDO(SDO), .SDO_OE(SDO_OE), .STANDBY(STANDBY), .ACTIVE(ACTIVE),
      .TX_LOAD(TX_LOAD), .RX_BYTE(RX_BYTE), .OP_REQ(OP_REQ), .GUARD(GUARD));
   // Undriven output reads inverted, never a stale bit
   assign sdo_line = SDO_OE ? SDO : ~SDO;
   spi_master_model master (
      .MCLK(MCLK), .SDO(sdo_line), .SCLK(SCLK), .SEL_N(SEL_N), .SDI(SDI),
      .PAUSE_N(PAUSE_N));
   initial MCLK = 1'b0;
   always #10 MCLK = ~MCLK;
   // Record bytes and requests as they pulse
   always @(posedge MCLK) begin
      if (RX_BYTE.valid === 1'b1) rx_q.push_back({RX_BYTE.first, RX_BYTE.data});
      if ((OP_REQ.prog | OP_REQ.erase_sec | OP_REQ.erase_all) === 1'b1) last_op = OP_REQ;
      if (TX_LOAD === 1'b1) n_loads++;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic give_verdict();
      if (n_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict
   task automatic strobe(input logic [1:0] v);
      GUARD_WR_DATA = v;
      GUARD_WR      = 1'b1;
      master.wait_cyc(1);
      GUARD_WR = 1'b0;
      master.wait_cyc(2);
   endtask : strobe
   // Select held low from power-up, never fallen
   task automatic t_no_fall();
      logic [7:0] rx;
      master.shift(8'h02, rx);
      master.shift(8'h01, rx);
      master.close();
      check(rx_q.size(), 0);
   endtask : t_no_fall
   // Mode 0 page program, read back the returned stream
   task automatic t_prog();
      logic [7:0] pp [6] = '{8'h02, 8'h01, 8'h23, 8'h45, 8'h3C, 8'h5A};
      logic [7:0] rx [6];
      int         loads0;
      master.open(1'b0);
      loads0 = n_loads;
      check({ACTIVE, STANDBY, SDO_OE}, 3'b101);
      // New word for the last byte proves that byte reloads from TX_DATA at its boundary fall
      foreach (pp[i]) begin
         if (i == 5) TX_DATA = 8'h3C;
         master.shift(pp[i], rx[i]);
      end
      master.close();
      check(rx[4], 8'hA5);
      check(rx[5], 8'h3C);
      // One load per byte boundary fall, the closing fall included
      check(n_loads - loads0, 6);
      check(rx_q.size(), 6);
      foreach (pp[i]) check(rx_q[i], {i == 0, pp[i]});
      check(last_op, {3'b100, 17'h12345});
   endtask : t_prog
   // Mode 3 sector erase, then whole array erase
   task automatic t_erase();
      logic [7:0] rx;
      for (int k = 0; k < 2; k++) begin
         master.open(1'b1);
         master.shift(k ? 8'hC7 : 8'hD8, rx);
         check(rx, 8'h3C);
         if (k == 0) begin
            master.shift(8'h01, rx);
            master.shift(8'h00, rx);
            master.shift(8'h00, rx);
         end
         master.close();
         check({last_op.erase_sec, last_op.erase_all}, k ? 2'b01 : 2'b10);
         if (k == 0) check(last_op.addr, 17'h10000);
      end
   endtask : t_erase
   // Pause mid-frame, then deselect while paused
   task automatic t_pause();
      logic [7:0] rx;
      rx_q.delete();
      master.open(1'b0);
      master.shift(8'h02, rx);
      master.hold_on(6);
      check(SDO_OE, 1'b0);
      master.hold_off();
      master.shift(8'h96, rx);
      master.hold_on(2);
      master.close();
      master.hold_off();
      check(rx_q.size(), 2);
      check(rx_q[1], 9'h096);
      master.open(1'b0);
      master.shift(8'h5A, rx);
      master.close();
      check(rx_q[2], 9'h15A);
   endtask : t_pause
   // Guard writes free, frozen, then free again
   task automatic t_guard();
      strobe(2'h3);
      check(GUARD, 2'h3);
      PROTECT_ENA = 1'b1;
      PROTECT_N   = 1'b0;
      master.wait_cyc(4);
      strobe(2'h1);
      check(GUARD, 2'h3);
      PROTECT_N = 1'b1;
      master.wait_cyc(4);
      strobe(2'h1);
      check(GUARD, 2'h1);
   endtask : t_guard
   // Internal cycle keeps the part active while deselected
   task automatic t_busy();
      BUSY = 1'b1;
      master.wait_cyc(6);
      check({ACTIVE, STANDBY}, 2'b10);
      BUSY = 1'b0;
      master.wait_cyc(6);
      check({ACTIVE, STANDBY}, 2'b01);
   endtask : t_busy
   initial begin
      NRST          = 1'b0;
      PROTECT_N     = 1'b1;
      BUSY          = 1'b0;
      GUARD_WR      = 1'b0;
      PROTECT_ENA   = 1'b0;
      TX_DATA       = 8'hA5;
      GUARD_WR_DATA = 2'h0;
      last_op       = '0;
      master.wait_cyc(16);
      NRST = 1'b1;
      check({SDO_OE, STANDBY, ACTIVE, GUARD}, {3'b010, flash_if_pkg::GUARD_RST});
      t_no_fall();
      t_prog();
      t_erase();
      t_pause();
      t_guard();
      t_busy();
      give_verdict();
   end
   // Watchdog well past the longest expected run
   initial begin
      #400000;
      n_errors++;
      give_verdict();
   end
endmodule : tb
`default_nettype wire
